// ---- rtl/clk_mode_consts.svh ----
// Purpose: Offsets, field positions, reset values for the clock mode controller
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Definitions only
`ifndef CLK_MODE_CONSTS_SVH
`define CLK_MODE_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_OSC_DETECT 8'h08
`define OFF_OSC_FREQ 8'h0C
`define OFF_PLL 8'h10
`define OFF_PROC_MODE_2 8'h14
`define OFF_STATUS 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_SUB_SEL 7
`define B_DIV8 6
`define B_MAIN_OFF 5
`define B_SUB_PORT 4
`define B_WAIT_STOP 2
`define B_DIV_HI 7
`define B_DIV_LO 6
`define B_PLL_SEL 1
`define B_OSC_SEL 1
`define B_PLL_RUN 7
`define B_WDT_OSC 2
`define B_ST_WAIT 3
`define B_ST_MULT 4

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define RST_DIV 2'h3
`define RST_OSC_SEL 1'h1
`define RST_OSC_FREQ 4'h0
`define RST_MULT 3'h0
`define SHIFT_DIV8 3'h3
`define SHIFT_DIV16 3'h4
`define SHIFT_SUB32 3'h5

`endif

// ---- rtl/clk_mode_pkg.sv ----
// Purpose: Types shared by the clock mode controller
// Assumes: Nothing
// Notes: Enumerations only
package clk_mode_pkg;

  typedef enum logic [2:0] {
    mode_high, mode_pll, mode_medium, mode_low,
    mode_low_power, mode_osc, mode_osc_low_power
  } mode_type;

  typedef enum logic [1:0] {
    src_main, src_sub, src_osc, src_pll
  } source_type;

endpackage

// ---- rtl/tick_divider.sv ----
// Purpose: Divides a source tick stream by 2**shift
// Assumes: src_tick is a one-cycle pulse per source period
// Notes: New ratio taken only at the wrap, so no short period leaves
`timescale 1ns/1ps
`include "clk_mode_consts.svh"

module tick_divider (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic src_tick,
  input wire logic [2:0] shift,
  output logic tick,
  output logic wrap
);

  logic [4:0] count;
  logic [2:0] cur_shift;
  logic [4:0] last;

  assign last = 5'((6'h01 << cur_shift) - 6'h01);
  assign wrap = src_tick && (count == last);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= 5'h00;
      cur_shift <= `SHIFT_DIV16;
      tick <= 1'b0;
    end else begin
      tick <= wrap;
      if (wrap) begin
        count <= 5'h00;
        cur_shift <= shift;
      end else if (src_tick) begin
        count <= count + 5'h01;
      end
    end
  end

endmodule // tick_divider

// ---- rtl/clock_mode_ctrl.sv ----
// Purpose: CPU clock mode, divider and wait mode control
// Assumes: Source clocks arrive as slow levels sampled on core_clk
// Notes: Clocks leave as one-cycle enables on core_clk
// Operation
// - High-speed: undivided main clock, all bits zero
// - PLL clocks CPU; entry only from high-speed
// - Medium-speed divider 2,4,16; divide-by-8 bit gives 8
// - Low-speed: sub clock CPU; periph main or oscillator
// - Main off in low-speed forces divide-by-8 bit
// - Low power: only sub div32; divide-by-8 bit frozen
// - Main clock returns in medium-speed divide-by-8
// - Oscillator mode: divided oscillator clocks CPU, undivided oscillator clocks peripherals
// - Four-bit oscillator frequency select field
// - Main off in oscillator mode: oscillator low power
// - Sub div32 always usable while sub clock runs
// - Wait stops CPU, watchdog unless oscillator source
// - All source clocks keep running during wait
// - Peripheral stop bit gates peripheral clocks in wait
// - Wait entered by wait instruction, no write
// - PLL multiplier writable once after reset
// - Reset: CPU from oscillator divided by 16
`timescale 1ns/1ps
`include "clk_mode_consts.svh"

module clock_mode_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic main_src,
  input wire logic sub_src,
  input wire logic osc_src,
  input wire logic pll_src,
  input wire logic wait_instr,
  input wire logic wake_event,
  output logic main_osc_enable,
  output logic sub_osc_enable,
  output logic osc_enable,
  output logic pll_enable,
  output logic [3:0] osc_freq_select,
  output logic [2:0] pll_multiplier,
  output logic cpu_clk_en,
  output logic watchdog_clk_en,
  output logic periph_clk_en,
  output logic serial_clock_div1,
  output logic converter_clock,
  output logic sub_div32_clock
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic clk_mode_pkg::mode_type mode_of(
    input logic sub_sel, input logic osc_sel, input logic pll_sel,
    input logic main_off, input logic div8, input logic [1:0] div);
    if (sub_sel) begin
      mode_of = main_off ? clk_mode_pkg::mode_low_power : clk_mode_pkg::mode_low;
    end else if (osc_sel) begin
      mode_of = main_off ? clk_mode_pkg::mode_osc_low_power : clk_mode_pkg::mode_osc;
    end else if (pll_sel) begin
      mode_of = clk_mode_pkg::mode_pll;
    end else if (div8 || (div != 2'h0)) begin
      mode_of = clk_mode_pkg::mode_medium;
    end else begin
      mode_of = clk_mode_pkg::mode_high;
    end
  endfunction

  // Ratio as a power of two; the divide-by-8 bit overrides the field
  function automatic logic [2:0] shift_of(input logic div8, input logic [1:0] div);
    if (div8) begin
      shift_of = `SHIFT_DIV8;
    end else if (div == 2'h3) begin
      shift_of = `SHIFT_DIV16;
    end else begin
      shift_of = {1'b0, div};
    end
  endfunction

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  logic sub_clock_cpu_select;
  logic divide_by_eight_bit;
  logic main_clock_off;
  logic sub_clock_port_function;
  logic wait_periph_clock_stop;
  logic cpu_divider_hi;
  logic cpu_divider_lo;
  logic pll_cpu_source_select;
  logic onchip_osc_select;
  logic pll_run;
  logic watchdog_osc_source;
  logic mult_written;
  logic in_wait;
  clk_mode_pkg::mode_type mode;

  logic access;
  logic take;
  logic wr_ctrl0;
  logic wr_ctrl1;

  assign access = read || write;
  assign take = write && !waitrequest;
  assign wr_ctrl0 = take && (address == `OFF_CTRL0);
  assign wr_ctrl1 = take && (address == `OFF_CTRL1);

  always_comb begin
    mode = mode_of(sub_clock_cpu_select, onchip_osc_select, pll_cpu_source_select,
      main_clock_off, divide_by_eight_bit, {cpu_divider_hi, cpu_divider_lo});
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state per access, then a single ready cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(access && waitrequest);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= 32'h0000_0000;
      if (address == `OFF_CTRL0) begin
        readdata[`B_SUB_SEL] <= sub_clock_cpu_select;
        readdata[`B_DIV8] <= divide_by_eight_bit;
        readdata[`B_MAIN_OFF] <= main_clock_off;
        readdata[`B_SUB_PORT] <= sub_clock_port_function;
        readdata[`B_WAIT_STOP] <= wait_periph_clock_stop;
      end else if (address == `OFF_CTRL1) begin
        readdata[`B_DIV_HI] <= cpu_divider_hi;
        readdata[`B_DIV_LO] <= cpu_divider_lo;
        readdata[`B_PLL_SEL] <= pll_cpu_source_select;
      end else if (address == `OFF_OSC_DETECT) begin
        readdata[`B_OSC_SEL] <= onchip_osc_select;
      end else if (address == `OFF_OSC_FREQ) begin
        readdata[3:0] <= osc_freq_select;
      end else if (address == `OFF_PLL) begin
        readdata[`B_PLL_RUN] <= pll_run;
        readdata[2:0] <= pll_multiplier;
      end else if (address == `OFF_PROC_MODE_2) begin
        readdata[`B_WDT_OSC] <= watchdog_osc_source;
      end else if (address == `OFF_STATUS) begin
        readdata[2:0] <= mode;
        readdata[`B_ST_WAIT] <= in_wait;
        readdata[`B_ST_MULT] <= mult_written;
      end
    end
  end

  // ----------------------------------------
  // Mode control registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sub_clock_cpu_select <= 1'b0;
      main_clock_off <= 1'b0;
      sub_clock_port_function <= 1'b0;
      wait_periph_clock_stop <= 1'b0;
    end else if (wr_ctrl0) begin
      sub_clock_cpu_select <= writedata[`B_SUB_SEL];
      main_clock_off <= writedata[`B_MAIN_OFF];
      sub_clock_port_function <= writedata[`B_SUB_PORT];
      wait_periph_clock_stop <= writedata[`B_WAIT_STOP];
    end
  end

  // Hardware force wins over the written value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divide_by_eight_bit <= 1'b0;
    end else if (wr_ctrl0) begin
      if (mode == clk_mode_pkg::mode_low && writedata[`B_MAIN_OFF]) begin
        divide_by_eight_bit <= 1'b1;
      end else if (mode != clk_mode_pkg::mode_low_power) begin
        divide_by_eight_bit <= writedata[`B_DIV8];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_divider_hi <= 1'(`RST_DIV >> 1);
      cpu_divider_lo <= 1'(`RST_DIV);
      pll_cpu_source_select <= 1'b0;
    end else if (wr_ctrl1) begin
      cpu_divider_hi <= writedata[`B_DIV_HI];
      cpu_divider_lo <= writedata[`B_DIV_LO];
      // Setting refused unless already in high-speed; clearing always allowed
      if (!writedata[`B_PLL_SEL] || mode == clk_mode_pkg::mode_high) begin
        pll_cpu_source_select <= writedata[`B_PLL_SEL];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      onchip_osc_select <= `RST_OSC_SEL;
    end else if (take && address == `OFF_OSC_DETECT) begin
      onchip_osc_select <= writedata[`B_OSC_SEL];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_freq_select <= `RST_OSC_FREQ;
    end else if (take && address == `OFF_OSC_FREQ) begin
      osc_freq_select <= writedata[3:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pll_run <= 1'b0;
      pll_multiplier <= `RST_MULT;
      mult_written <= 1'b0;
    end else if (take && address == `OFF_PLL) begin
      pll_run <= writedata[`B_PLL_RUN];
      if (!mult_written) begin
        pll_multiplier <= writedata[2:0];
        mult_written <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      watchdog_osc_source <= 1'b0;
    end else if (take && address == `OFF_PROC_MODE_2) begin
      watchdog_osc_source <= writedata[`B_WDT_OSC];
    end
  end

  // ----------------------------------------
  // Wait mode
  // ----------------------------------------
  // Wake has priority so a wake in the entry cycle is not lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_wait <= 1'b0;
    end else if (wake_event) begin
      in_wait <= 1'b0;
    end else if (wait_instr) begin
      in_wait <= 1'b1;
    end
  end

  // ----------------------------------------
  // Oscillator enables
  // ----------------------------------------
  // Wait does not touch any source enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_osc_enable <= 1'b1;
      sub_osc_enable <= 1'b0;
      osc_enable <= 1'b1;
      pll_enable <= 1'b0;
    end else begin
      main_osc_enable <= !main_clock_off;
      sub_osc_enable <= sub_clock_port_function;
      osc_enable <= onchip_osc_select;
      pll_enable <= pll_run;
    end
  end

  // ----------------------------------------
  // Source synchronisers and edge ticks
  // ----------------------------------------
  logic [3:0] src_raw;
  logic [3:0] src_meta;
  logic [3:0] src_sync;
  logic [3:0] src_prev;
  logic [3:0] src_tick;

  assign src_raw = {pll_src, osc_src, sub_src, main_src};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_src
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          src_meta[g] <= 1'b0;
          src_sync[g] <= 1'b0;
          src_prev[g] <= 1'b0;
        end else begin
          src_meta[g] <= src_raw[g];
          src_sync[g] <= src_meta[g];
          src_prev[g] <= src_sync[g];
        end
      end
      assign src_tick[g] = src_sync[g] && !src_prev[g];
    end
  endgenerate

  // ----------------------------------------
  // CPU clock path
  // ----------------------------------------
  clk_mode_pkg::source_type want_src;
  clk_mode_pkg::source_type cpu_src;
  logic [2:0] want_shift;
  logic cpu_src_tick;
  logic cpu_div_tick;
  logic cpu_wrap;

  always_comb begin
    want_src = clk_mode_pkg::src_main;
    want_shift = shift_of(divide_by_eight_bit, {cpu_divider_hi, cpu_divider_lo});
    if (sub_clock_cpu_select) begin
      want_src = clk_mode_pkg::src_sub;
      want_shift = 3'h0;
    end else if (onchip_osc_select) begin
      want_src = clk_mode_pkg::src_osc;
    end else if (pll_cpu_source_select) begin
      want_src = clk_mode_pkg::src_pll;
      want_shift = 3'h0;
    end
  end

  // Source changes only on a divided-period boundary
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_src <= clk_mode_pkg::src_osc;
    end else if (cpu_wrap) begin
      cpu_src <= want_src;
    end
  end

  assign cpu_src_tick = src_tick[cpu_src];

  tick_divider u_cpu_div (
    .core_clk(core_clk),
    .rst(rst),
    .src_tick(cpu_src_tick),
    .shift(want_shift),
    .tick(cpu_div_tick),
    .wrap(cpu_wrap)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en <= 1'b0;
      watchdog_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= cpu_div_tick && !in_wait;
      watchdog_clk_en <= in_wait ?
        (watchdog_osc_source && src_tick[clk_mode_pkg::src_osc]) :
        cpu_div_tick;
    end
  end

  // ----------------------------------------
  // Peripheral clock path
  // ----------------------------------------
  logic periph_on;
  logic periph_src_tick;

  always_comb begin
    periph_on = 1'b1;
    periph_src_tick = src_tick[clk_mode_pkg::src_main];
    if (mode == clk_mode_pkg::mode_low_power) begin
      periph_on = 1'b0;
    end else if (mode == clk_mode_pkg::mode_low) begin
      periph_src_tick = onchip_osc_select ?
        src_tick[clk_mode_pkg::src_osc] : src_tick[clk_mode_pkg::src_main];
    end else if (mode == clk_mode_pkg::mode_osc || mode == clk_mode_pkg::mode_osc_low_power) begin
      periph_src_tick = src_tick[clk_mode_pkg::src_osc];
    end else if (mode == clk_mode_pkg::mode_pll) begin
      periph_src_tick = src_tick[clk_mode_pkg::src_pll];
    end
    if (in_wait && wait_periph_clock_stop) begin
      periph_on = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periph_clk_en <= 1'b0;
      serial_clock_div1 <= 1'b0;
      converter_clock <= 1'b0;
    end else begin
      periph_clk_en <= periph_on && periph_src_tick;
      serial_clock_div1 <= periph_on && periph_src_tick;
      converter_clock <= periph_on && periph_src_tick;
    end
  end

  // Sub div32 has no gate: running in every mode and in wait
  tick_divider u_sub_div32 (
    .core_clk(core_clk),
    .rst(rst),
    .src_tick(src_tick[clk_mode_pkg::src_sub]),
    .shift(`SHIFT_SUB32),
    .tick(sub_div32_clock),
    .wrap()
  );

endmodule // clock_mode_ctrl

// ---- tb/clock_mode_ctrl_props.sv ----
// Purpose: Port assertions for the clock mode controller
// Assumes: Source levels hold each level at least 3 cycles
// Notes: Bound after the module
`timescale 1ns/1ps
`include "clk_mode_consts.svh"

module clock_mode_ctrl_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic wait_instr,
  input wire logic wake_event,
  input wire logic [3:0] osc_freq_select,
  input wire logic [2:0] pll_multiplier,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic sub_div32_clock
);
  // ------------------------------
  // Accepted writes
  // ------------------------------
  logic mult_seen;
  logic freq_taken;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mult_seen <= 1'h0;
      freq_taken <= 1'h0;
    end else begin
      mult_seen <= mult_seen || (write && !waitrequest && address == `OFF_PLL);
      freq_taken <= write && !waitrequest && address == `OFF_OSC_FREQ;
    end
  end

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence bus_pending;
    (read || write) && waitrequest;
  endsequence

  // Three quiet cycles leave room for a pulse already in flight
  sequence wait_entry;
    wait_instr && !wake_event ##1 (!wake_event) [*3];
  endsequence

  bus_answer_a: assert property (bus_pending |=> !waitrequest)
    else $error("waitrequest held past one wait state");
  bus_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low two cycles");
  cpu_no_runt_a: assert property (cpu_clk_en |=> !cpu_clk_en [*2])
    else $error("cpu_clk_en runt period");
  periph_no_runt_a: assert property (periph_clk_en |=> !periph_clk_en [*2])
    else $error("periph_clk_en runt period");
  wait_stop_a: assert property (wait_entry |-> !cpu_clk_en)
    else $error("cpu_clk_en pulsed in wait");
  sub32_gap_a: assert property (sub_div32_clock |=> !sub_div32_clock [*8])
    else $error("sub_div32_clock too fast");
  mult_once_a: assert property (mult_seen |=> $stable(pll_multiplier))
    else $error("pll_multiplier changed after first write");
  freq_write_a: assert property ($changed(osc_freq_select) |-> freq_taken)
    else $error("osc_freq_select changed without a write");
endmodule // clock_mode_ctrl_props

bind clock_mode_ctrl clock_mode_ctrl_props u_props (
  .core_clk, .rst, .address, .read, .write, .waitrequest, .wait_instr, .wake_event,
  .osc_freq_select, .pll_multiplier, .cpu_clk_en, .periph_clk_en, .sub_div32_clock
);

// ---- tb/cpu_clock_mode_and_wait_control_tb_top.sv ----
// Purpose: Self-checking bench for the clock mode controller
// Assumes: Sources from one counter: main, PLL 8, oscillator 16, sub 32 cycles
// Notes: Integer model of the fields predicts reads, modes and periods
`timescale 1ns/1ps

module cpu_clock_mode_and_wait_control_tb_top;
  logic core_clk, rst, read, write, wait_instr, wake_event, waitrequest;
  logic main_osc_enable, sub_osc_enable, osc_enable, pll_enable, cpu_clk_en;
  logic watchdog_clk_en, periph_clk_en, serial_clock_div1, converter_clock, sub_div32_clock;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] osc_freq_select, en;
  logic [2:0] pll_multiplier;
  logic [5:0] cyc, pv;
  logic [15:0] lf;
  int failures, samples_checked, n, i, j, sub, d8, moff, sp, wst, pll;
  int freq, mult, mw, run, wdt, wt;
  int dv = 3;
  int osel = 1;

  clock_mode_ctrl u_dut (
    .core_clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .main_src(cyc[2]), .sub_src(cyc[4]), .osc_src(cyc[3]), .pll_src(cyc[2]),
    .wait_instr, .wake_event, .main_osc_enable, .sub_osc_enable, .osc_enable, .pll_enable,
    .osc_freq_select, .pll_multiplier, .cpu_clk_en, .watchdog_clk_en, .periph_clk_en,
    .serial_clock_div1, .converter_clock, .sub_div32_clock
  );

  assign pv = {watchdog_clk_en, sub_div32_clock, serial_clock_div1, converter_clock,
    periph_clk_en, cpu_clk_en};
  assign en = {main_osc_enable, sub_osc_enable, osc_enable, pll_enable};

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Sources never pause, so every switch lands on a settled clock
  always @(posedge core_clk) cyc <= cyc + 6'h01;

  // ------------------------------
  // Model and checks
  // ------------------------------
  function automatic int md();
    if (sub) return moff ? 4 : 3;
    if (osel) return moff ? 6 : 5;
    if (pll) return 1;
    return (dv != 0 || d8) ? 2 : 0;
  endfunction

  function automatic int per();
    int r;
    r = d8 ? 8 : (dv == 3 ? 16 : 1 << dv);
    case (md())
      1: return 8;
      3, 4: return 32;
      5, 6: return 16 * r;
      default: return 8 * r;
    endcase
  endfunction

  function automatic logic [31:0] rexp(input logic [7:0] a);
    logic [2:0] m;
    m = 3'(md());
    case (a)
      8'h00: return {sub[0], d8[0], moff[0], sp[0], 1'h0, wst[0], 2'h0};
      8'h04: return {dv[1:0], 4'h0, pll[0], 1'h0};
      8'h08: return {osel[0], 1'h0};
      8'h0C: return freq;
      8'h10: return {run[0], 4'h0, mult[2:0]};
      8'h14: return {wdt[0], 2'h0};
      8'h18: return {mw[0], wt[0], m};
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("Compared %0d, mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tmo;
    failures++;
    end_sim();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int m, k;
    m = md();
    @(posedge core_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (waitrequest === 1'h0) break;
    end
    if (k == 50) tmo();
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (wr) begin
      case (a)
        8'h00: begin
          if (m != 4) d8 = (m == 3 && d[5]) ? 1 : d[6];
          sub = d[7];
          moff = d[5];
          sp = d[4];
          wst = d[2];
        end
        8'h04: begin
          dv = d[7:6];
          pll = d[1] && (pll || m == 0);
        end
        8'h08: osel = d[1];
        8'h0C: freq = d[3:0];
        8'h10: begin
          run = d[7];
          if (!mw) mult = d[2:0];
          mw = 1;
        end
        8'h14: wdt = d[2];
        default: ;
      endcase
    end
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
    chk($sformatf("reg %0h", a), q, rexp(a));
  endtask

  task automatic wpulse(input int s);
    int k;
    for (k = 0; k < 3000 && pv[s] !== 1'h1; k++) @(posedge core_clk);
    if (k == 3000) tmo();
    @(posedge core_clk);
  endtask

  // Skips the pulse that may still carry the old ratio
  task automatic period(input int s, input int exp);
    int k;
    wpulse(s);
    wpulse(s);
    for (k = 1; k < 3000 && pv[s] !== 1'h1; k++) @(posedge core_clk);
    if (k == 3000) tmo();
    chk($sformatf("period %0d", s), k, exp);
  endtask

  task automatic tally(input int s, input int len);
    n = 0;
    repeat (len) begin
      @(posedge core_clk);
      if (pv[s] === 1'h1) n++;
    end
  endtask

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    rst = 1'h1;
    read = 1'h0;
    write = 1'h0;
    address = 8'h00;
    writedata = 32'h0;
    wait_instr = 1'h0;
    wake_event = 1'h0;
    cyc = 6'h00;
    lf = 16'h0B93;
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    for (i = 0; i < 32; i += 4) rd(i[7:0]);
    period(0, per());
    for (i = 0; i < 4; i++) begin
      bus(1'h1, 8'h04, i << 6);
      period(0, per());
    end
    bus(1'h1, 8'h00, 32'h40);
    period(0, per());
    bus(1'h1, 8'h08, 32'h0);
    rd(8'h18);
    period(0, per());
    bus(1'h1, 8'h00, 32'h0);
    for (i = 3; i >= 0; i--) begin
      bus(1'h1, 8'h04, i << 6);
      rd(8'h18);
      period(0, per());
    end
    bus(1'h1, 8'h04, 32'hC0);
    bus(1'h1, 8'h04, 32'hC2);
    rd(8'h04);
    bus(1'h1, 8'h04, 32'h0);
    bus(1'h1, 8'h04, 32'h2);
    rd(8'h18);
    period(0, per());
    bus(1'h1, 8'h04, 32'h0);
    bus(1'h1, 8'h10, 32'h82);
    rd(8'h10);
    chk("source enables", en, {!moff[0], sp[0], osel[0], run[0]});
    bus(1'h1, 8'h10, 32'h5);
    rd(8'h10);
    rd(8'h18);
    chk("pll_multiplier", pll_multiplier, mult);
    repeat (3) begin
      lf = lfsr(lf);
      bus(1'h1, 8'h0C, lf);
      rd(8'h0C);
      chk("osc_freq_select", osc_freq_select, freq);
    end
    bus(1'h1, 8'h00, 32'h90);
    rd(8'h18);
    period(0, per());
    period(1, 8);
    bus(1'h1, 8'h08, 32'h2);
    period(1, 16);
    bus(1'h1, 8'h00, 32'hB0);
    rd(8'h00);
    rd(8'h18);
    chk("main_osc_enable", main_osc_enable, 0);
    tally(1, 300);
    chk("periph pulses", n, 0);
    bus(1'h1, 8'h00, 32'hB0);
    rd(8'h00);
    bus(1'h1, 8'h08, 32'h0);
    bus(1'h1, 8'h00, 32'h10);
    rd(8'h18);
    period(0, per());
    bus(1'h1, 8'h08, 32'h2);
    bus(1'h1, 8'h00, 32'h60);
    rd(8'h18);
    chk("main_osc_enable", main_osc_enable, 0);
    period(0, per());
    period(1, 16);
    for (i = 0; i < 2; i++) begin
      bus(1'h1, 8'h00, 32'h40 | i << 2);
      bus(1'h1, 8'h14, i << 2);
      @(posedge core_clk);
      wait_instr <= 1'h1;
      @(posedge core_clk);
      wait_instr <= 1'h0;
      wt = 1;
      rd(8'h18);
      chk("source enables", en, {!moff[0], sp[0], osel[0], run[0]});
      for (j = 0; j < 6; j++) begin
        tally(j, 1100);
        chk($sformatf("pulses %0d", j), n > 0, j == 4 || (j == 5 && i) || (j inside {[1:3]} && !i));
      end
      @(posedge core_clk);
      wake_event <= 1'h1;
      @(posedge core_clk);
      wake_event <= 1'h0;
      wt = 0;
      period(0, per());
    end
    end_sim();
  end
endmodule // cpu_clock_mode_and_wait_control_tb_top
